// ---- verilog/rtc_status_pkg.sv ----
// Package with register map, field positions, reset values and timing counts.
package rtc_status_pkg;

    // =====================================================================
    // Register offsets
    // =====================================================================
    localparam logic [3:0] INTERRUPT_CONFIG_ADDR = 4'hE;
    localparam logic [3:0] STATUS_FLAGS_ADDR = 4'hF;

    // =====================================================================
    // Field positions of interrupt_config
    // =====================================================================
    localparam int WEEKLY_ALARM_EN_BIT = 7;
    localparam int DAILY_ALARM_EN_BIT = 6;
    localparam int HOUR_FORMAT_BIT = 5;
    localparam int CLKOUT_DISABLE_B_BIT = 4;
    localparam int TEST_BIT = 3;
    localparam int PERIODIC_SELECT_LSB = 0;

    // =====================================================================
    // Field positions of status_flags
    // =====================================================================
    localparam int THRESHOLD_SELECT_BIT = 7;
    localparam int LOW_SUPPLY_FLAG_BIT = 6;
    localparam int OSC_RUNNING_N_FLAG_BIT = 5;
    localparam int POWER_UP_FLAG_BIT = 4;
    localparam int CLKOUT_DISABLE_A_BIT = 3;
    localparam int PERIODIC_FLAG_BIT = 2;
    localparam int WEEKLY_ALARM_FLAG_BIT = 1;
    localparam int DAILY_ALARM_FLAG_BIT = 0;

    // =====================================================================
    // Reset values
    // =====================================================================
    localparam logic [7:0] INTERRUPT_CONFIG_RESET = 8'h00;
    localparam logic [7:0] STATUS_FLAGS_RESET = 8'h10;
    localparam logic [7:0] TRIM_RESET = 8'h00;

    // =====================================================================
    // Timing
    // =====================================================================
    localparam int CLK_HZ = 50_000_000;
    localparam int SAMPLE_WINDOW_US = 7800;
    localparam int SAMPLE_WINDOW_CYCLES = SAMPLE_WINDOW_US * (CLK_HZ / 1_000_000);
    localparam int SECOND_CYCLES = CLK_HZ;
    localparam int HALF_SECOND_CYCLES = CLK_HZ / 2;

    // =====================================================================
    // Types
    // =====================================================================
    typedef enum logic [2:0] {
        PSEL_OFF,
        PSEL_LOW,
        PSEL_2HZ,
        PSEL_1HZ,
        PSEL_SEC,
        PSEL_MIN,
        PSEL_HOUR,
        PSEL_MONTH
    } periodic_select_type;

    typedef struct packed {
        logic second;
        logic minute;
        logic hour;
        logic month;
    } period_tick_type;

    typedef struct packed {
        logic [2:0] day_of_week;
        logic [5:0] hour;
        logic [6:0] minute;
    } alarm_time_type;

endpackage

// ---- verilog/rtc_sync2.sv ----
// Two flip-flop level synchroniser.
module rtc_sync2 (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic async_in,
    output logic sync_out
);

    logic meta_reg;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_reg <= 1'b0;
            sync_out <= 1'b0;
        end else begin
            meta_reg <= async_in;
            sync_out <= meta_reg;
        end
    end

endmodule

// ---- verilog/rtc_supply_sampler.sv ----
// Duty-cycled supply sampler: one sampling window per second.
module rtc_supply_sampler #(
    parameter int SECOND_CYCLES = rtc_status_pkg::SECOND_CYCLES,
    parameter int WINDOW_CYCLES = rtc_status_pkg::SAMPLE_WINDOW_CYCLES
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic suspend,
    input wire logic below_sync,
    output logic window_active,
    output logic low_detect
);

    logic [31:0] count_reg;

    // =====================================================================
    // Second counter with sampling window at its start.
    // =====================================================================
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count_reg <= 32'h00000000;
        end else if (count_reg >= 32'(SECOND_CYCLES - 1)) begin
            count_reg <= 32'h00000000;
        end else begin
            count_reg <= count_reg + 32'h00000001;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            window_active <= 1'b0;
            low_detect <= 1'b0;
        end else begin
            window_active <= !suspend && (count_reg < 32'(WINDOW_CYCLES));
            low_detect <= !suspend && (count_reg < 32'(WINDOW_CYCLES)) && below_sync;
        end
    end

endmodule

// ---- verilog/rtc_status_monitor_interrupt.sv ----
// Status flags, supply monitor and interrupt output of the clock.

// How it works
// - Power-on reset clears both control registers, trim.
// - Power-up flag D4 at Fh sets on power-up.
// - Oscillator-running flag D5 is active low.
// - Oscillator halt clears running flag until rewritten.
// - Power-up, low-supply flags accept only written zeros.
// - Power-up flag holds listed fields at zero.
// - Supply sampled 7.8 ms once each second.
// - Threshold select: 0 is 2.1 V, 1 is 1.3 V.
// - Sampling stops while low-supply flag is set.
// - Weekly and daily alarm matches assert interrupt.
// - Periodic source drives pulse or level mode.
// - Flags D0 daily, D1 weekly, D2 periodic.
// - Enables D7 weekly, D6 daily; select zero disables.
// - All enables zero keeps interrupt released.
// - Interrupt low when any source asserts.
// - Writing zero clears alarm flag, keeps enable.
// - Select codes: off, low, 2 Hz, 1 Hz, levels.
// - Level mode stays low until periodic flag cleared.
module rtc_status_monitor_interrupt #(
    parameter int SECOND_CYCLES = rtc_status_pkg::SECOND_CYCLES,
    parameter int HALF_SECOND_CYCLES = rtc_status_pkg::HALF_SECOND_CYCLES,
    parameter int WINDOW_CYCLES = rtc_status_pkg::SAMPLE_WINDOW_CYCLES
) (
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic [3:0] REG_ADDR,
    input wire logic REG_WRITE,
    input wire logic [7:0] REG_WDATA,
    input wire logic TRIM_WRITE,
    output logic [7:0] REG_RDATA,
    output logic [7:0] TRIM_VALUE,
    input wire logic OSC_HALTED,
    input wire logic BELOW_2V1,
    input wire logic BELOW_1V3,
    output logic SAMPLE_ENABLE,
    output logic THRESHOLD_SELECT,
    input wire rtc_status_pkg::period_tick_type PERIOD_TICK,
    input wire logic SECONDS_WRITE,
    input wire rtc_status_pkg::alarm_time_type CURRENT_TIME,
    input wire rtc_status_pkg::alarm_time_type WEEKLY_ALARM_TIME,
    input wire rtc_status_pkg::alarm_time_type DAILY_ALARM_TIME,
    output logic IRQ_N_OE,
    output logic IRQ_N_OUT
);

    logic [7:0] interrupt_config_reg;
    logic power_up_flag_reg;
    logic osc_running_n_flag_reg;
    logic low_supply_flag_reg;
    logic threshold_select_reg;
    logic clkout_disable_a_reg;
    logic periodic_flag_reg;
    logic weekly_alarm_flag_reg;
    logic daily_alarm_flag_reg;
    logic [7:0] trim_reg;
    logic [31:0] pulse_count_reg;
    logic pulse_low_reg;
    logic weekly_match_reg;
    logic daily_match_reg;
    logic halt_sync;
    logic below_2v1_sync;
    logic below_1v3_sync;
    logic window_active;
    logic low_detect;
    logic below_selected;
    logic write_config;
    logic write_status;
    logic weekly_match;
    logic daily_match;
    logic level_event;
    logic periodic_req;
    logic request_n;
    logic [7:0] status_read;
    rtc_status_pkg::periodic_select_type periodic_select;

    // =====================================================================
    // Decode and input conditioning
    // =====================================================================
    assign write_config = REG_WRITE && (REG_ADDR == rtc_status_pkg::INTERRUPT_CONFIG_ADDR);
    assign write_status = REG_WRITE && (REG_ADDR == rtc_status_pkg::STATUS_FLAGS_ADDR);
    assign periodic_select = rtc_status_pkg::periodic_select_type'(
        interrupt_config_reg[rtc_status_pkg::PERIODIC_SELECT_LSB +: 3]);
    assign below_selected = threshold_select_reg ? below_1v3_sync : below_2v1_sync;

    rtc_sync2 halt_sync_inst (
        .clk(CLK),
        .rst_n(RST_N),
        .async_in(OSC_HALTED),
        .sync_out(halt_sync)
    );

    // Both comparators are synchronised before the select, so a threshold change takes effect at once.
    rtc_sync2 below_2v1_sync_inst (
        .clk(CLK),
        .rst_n(RST_N),
        .async_in(BELOW_2V1),
        .sync_out(below_2v1_sync)
    );

    rtc_sync2 below_1v3_sync_inst (
        .clk(CLK),
        .rst_n(RST_N),
        .async_in(BELOW_1V3),
        .sync_out(below_1v3_sync)
    );

    rtc_supply_sampler #(
        .SECOND_CYCLES(SECOND_CYCLES),
        .WINDOW_CYCLES(WINDOW_CYCLES)
    ) sampler_inst (
        .clk(CLK),
        .rst_n(RST_N),
        .suspend(low_supply_flag_reg),
        .below_sync(below_selected),
        .window_active(window_active),
        .low_detect(low_detect)
    );

    // =====================================================================
    // Power-up flag
    // =====================================================================
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            power_up_flag_reg <= 1'b1;
        end else if (write_status && !REG_WDATA[rtc_status_pkg::POWER_UP_FLAG_BIT]) begin
            power_up_flag_reg <= 1'b0;
        end
    end

    // =====================================================================
    // Oscillator-running flag, active low
    // =====================================================================
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            osc_running_n_flag_reg <= 1'b0;
        end else if (halt_sync) begin
            osc_running_n_flag_reg <= 1'b0;
        end else if (write_status) begin
            osc_running_n_flag_reg <= REG_WDATA[rtc_status_pkg::OSC_RUNNING_N_FLAG_BIT];
        end
    end

    // =====================================================================
    // Low-supply flag
    // =====================================================================
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            low_supply_flag_reg <= 1'b0;
        end else if (power_up_flag_reg) begin
            low_supply_flag_reg <= 1'b0;
        end else if (low_detect) begin
            low_supply_flag_reg <= 1'b1;
        end else if (write_status && !REG_WDATA[rtc_status_pkg::LOW_SUPPLY_FLAG_BIT]) begin
            low_supply_flag_reg <= 1'b0;
        end
    end

    // =====================================================================
    // Control fields of both registers and trim
    // =====================================================================
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            interrupt_config_reg <= rtc_status_pkg::INTERRUPT_CONFIG_RESET;
            threshold_select_reg <= 1'b0;
            clkout_disable_a_reg <= 1'b0;
            trim_reg <= rtc_status_pkg::TRIM_RESET;
        end else if (power_up_flag_reg) begin
            interrupt_config_reg <= rtc_status_pkg::INTERRUPT_CONFIG_RESET;
            threshold_select_reg <= 1'b0;
            clkout_disable_a_reg <= 1'b0;
            trim_reg <= rtc_status_pkg::TRIM_RESET;
        end else begin
            if (write_config) begin
                interrupt_config_reg <= REG_WDATA;
            end
            if (write_status) begin
                threshold_select_reg <= REG_WDATA[rtc_status_pkg::THRESHOLD_SELECT_BIT];
                clkout_disable_a_reg <= REG_WDATA[rtc_status_pkg::CLKOUT_DISABLE_A_BIT];
            end
            if (TRIM_WRITE) begin
                trim_reg <= REG_WDATA;
            end
        end
    end

    // =====================================================================
    // Alarm matchers and flags
    // =====================================================================
    assign weekly_match = (CURRENT_TIME == WEEKLY_ALARM_TIME);
    assign daily_match = (CURRENT_TIME.hour == DAILY_ALARM_TIME.hour)
        && (CURRENT_TIME.minute == DAILY_ALARM_TIME.minute);

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            weekly_match_reg <= 1'b0;
            daily_match_reg <= 1'b0;
        end else begin
            weekly_match_reg <= weekly_match;
            daily_match_reg <= daily_match;
        end
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            weekly_alarm_flag_reg <= 1'b0;
            daily_alarm_flag_reg <= 1'b0;
        end else if (power_up_flag_reg) begin
            weekly_alarm_flag_reg <= 1'b0;
            daily_alarm_flag_reg <= 1'b0;
        end else begin
            if (interrupt_config_reg[rtc_status_pkg::WEEKLY_ALARM_EN_BIT]
                && weekly_match && !weekly_match_reg) begin
                weekly_alarm_flag_reg <= 1'b1;
            end else if (write_status
                && !REG_WDATA[rtc_status_pkg::WEEKLY_ALARM_FLAG_BIT]) begin
                weekly_alarm_flag_reg <= 1'b0;
            end
            if (interrupt_config_reg[rtc_status_pkg::DAILY_ALARM_EN_BIT]
                && daily_match && !daily_match_reg) begin
                daily_alarm_flag_reg <= 1'b1;
            end else if (write_status
                && !REG_WDATA[rtc_status_pkg::DAILY_ALARM_FLAG_BIT]) begin
                daily_alarm_flag_reg <= 1'b0;
            end
        end
    end

    // =====================================================================
    // Periodic source: pulse-mode square waves and level-mode flag
    // =====================================================================
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            pulse_count_reg <= 32'h00000000;
            pulse_low_reg <= 1'b0;
        end else if (PERIOD_TICK.second || SECONDS_WRITE) begin
            pulse_count_reg <= 32'h00000000;
            pulse_low_reg <= 1'b1;
        end else begin
            pulse_count_reg <= pulse_count_reg + 32'h00000001;
            case (periodic_select)
                rtc_status_pkg::PSEL_2HZ: begin
                    if (pulse_count_reg == 32'(HALF_SECOND_CYCLES / 2 - 1)) begin
                        pulse_low_reg <= 1'b0;
                    end else if (pulse_count_reg == 32'(HALF_SECOND_CYCLES - 1)) begin
                        pulse_low_reg <= 1'b1;
                    end else if (pulse_count_reg == 32'(HALF_SECOND_CYCLES * 3 / 2 - 1)) begin
                        pulse_low_reg <= 1'b0;
                    end
                end
                rtc_status_pkg::PSEL_1HZ: begin
                    if (pulse_count_reg == 32'(HALF_SECOND_CYCLES - 1)) begin
                        pulse_low_reg <= 1'b0;
                    end
                end
                default: begin
                    pulse_low_reg <= pulse_low_reg;
                end
            endcase
        end
    end

    always_comb begin
        case (periodic_select)
            rtc_status_pkg::PSEL_SEC: level_event = PERIOD_TICK.second;
            rtc_status_pkg::PSEL_MIN: level_event = PERIOD_TICK.minute;
            rtc_status_pkg::PSEL_HOUR: level_event = PERIOD_TICK.hour;
            rtc_status_pkg::PSEL_MONTH: level_event = PERIOD_TICK.month;
            default: level_event = 1'b0;
        endcase
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            periodic_flag_reg <= 1'b0;
        end else if (power_up_flag_reg) begin
            periodic_flag_reg <= 1'b0;
        end else if (level_event) begin
            periodic_flag_reg <= 1'b1;
        end else if (periodic_select == rtc_status_pkg::PSEL_2HZ
            || periodic_select == rtc_status_pkg::PSEL_1HZ) begin
            periodic_flag_reg <= pulse_low_reg;
        end else if (write_status && !REG_WDATA[rtc_status_pkg::PERIODIC_FLAG_BIT]) begin
            periodic_flag_reg <= 1'b0;
        end
    end

    always_comb begin
        case (periodic_select)
            rtc_status_pkg::PSEL_OFF: periodic_req = 1'b0;
            rtc_status_pkg::PSEL_LOW: periodic_req = 1'b1;
            rtc_status_pkg::PSEL_2HZ: periodic_req = pulse_low_reg;
            rtc_status_pkg::PSEL_1HZ: periodic_req = pulse_low_reg;
            default: periodic_req = periodic_flag_reg;
        endcase
    end

    // =====================================================================
    // Combined interrupt and open-drain output
    // =====================================================================
    assign request_n = !((weekly_alarm_flag_reg
        && interrupt_config_reg[rtc_status_pkg::WEEKLY_ALARM_EN_BIT])
        || (daily_alarm_flag_reg && interrupt_config_reg[rtc_status_pkg::DAILY_ALARM_EN_BIT])
        || periodic_req);

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            IRQ_N_OE <= 1'b0;
            IRQ_N_OUT <= 1'b0;
        end else begin
            IRQ_N_OE <= !request_n;
            IRQ_N_OUT <= 1'b0;
        end
    end

    // =====================================================================
    // Read data and monitor outputs
    // =====================================================================
    assign status_read = {threshold_select_reg, low_supply_flag_reg, osc_running_n_flag_reg,
        power_up_flag_reg, clkout_disable_a_reg, periodic_flag_reg, weekly_alarm_flag_reg,
        daily_alarm_flag_reg};

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            REG_RDATA <= 8'h00;
            TRIM_VALUE <= 8'h00;
            SAMPLE_ENABLE <= 1'b0;
            THRESHOLD_SELECT <= 1'b0;
        end else begin
            if (REG_ADDR == rtc_status_pkg::INTERRUPT_CONFIG_ADDR) begin
                REG_RDATA <= interrupt_config_reg;
            end else if (REG_ADDR == rtc_status_pkg::STATUS_FLAGS_ADDR) begin
                REG_RDATA <= status_read;
            end else begin
                REG_RDATA <= 8'h00;
            end
            TRIM_VALUE <= trim_reg;
            SAMPLE_ENABLE <= window_active;
            THRESHOLD_SELECT <= threshold_select_reg;
        end
    end

endmodule

// ---- testbench/rtc_status_monitor_interrupt_props.sv ----
// Checker of the status flags, supply sampler and interrupt output.
module rtc_status_monitor_interrupt_props #(
    parameter int WINDOW_CYCLES = 20
) (
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic [3:0] REG_ADDR,
    input wire logic REG_WRITE,
    input wire logic [7:0] REG_WDATA,
    input wire logic [7:0] REG_RDATA,
    input wire logic [7:0] TRIM_VALUE,
    input wire logic SAMPLE_ENABLE,
    input wire logic THRESHOLD_SELECT,
    input wire logic IRQ_N_OE,
    input wire logic IRQ_N_OUT
);
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================================
    // Assertions
    int hi_cnt;
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!RST_N);
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            hi_cnt <= 0;
        end else begin
            hi_cnt <= SAMPLE_ENABLE ? hi_cnt + 1 : 0;
        end
    end
    sequence clear_s;
        REG_WRITE && REG_ADDR == 4'hF && !REG_WDATA[4] ##1 (REG_ADDR == 4'hF) [*2];
    endsequence
    sequence pon_s;
        $past(REG_ADDR) == 4'hF && REG_RDATA[4];
    endsequence
    AST_PON_CLEAR: assert property (clear_s |=> !REG_RDATA[4])
        else $error("Power-up flag survived a zero write.");
    AST_PON_STATUS: assert property (pon_s |-> (REG_RDATA & 8'hCF) == 8'h00)
        else $error("Status field not held at zero.");
    AST_PON_TRIM: assert property (pon_s |-> TRIM_VALUE == 8'h00 && !THRESHOLD_SELECT)
        else $error("Trim or threshold not held at zero.");
    AST_PON_IRQ: assert property (pon_s |-> !IRQ_N_OE)
        else $error("Interrupt pulled while power-up flag set.");
    AST_IRQ_IDLE: assert property ($rose(RST_N) |-> (!IRQ_N_OE) [*3])
        else $error("Interrupt pulled right after reset.");
    AST_OUT_LOW: assert property (IRQ_N_OUT == 1'h0)
        else $error("Interrupt output level not low.");
    AST_WINDOW_BOUND: assert property (SAMPLE_ENABLE |-> hi_cnt < WINDOW_CYCLES)
        else $error("Sampling window too long.");
    AST_NO_SAMPLE: assert property (($past(REG_ADDR) == 4'hF && REG_RDATA[6]
        && !$past(REG_WRITE) && !REG_WRITE
        ##1 !REG_WRITE) |=> !SAMPLE_ENABLE)
        else $error("Sampling while low-supply flag set.");
endmodule

bind rtc_status_monitor_interrupt rtc_status_monitor_interrupt_props #(
    .WINDOW_CYCLES(WINDOW_CYCLES)
) props_u (
    .CLK(CLK), .RST_N(RST_N), .REG_ADDR(REG_ADDR), .REG_WRITE(REG_WRITE),
    .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA), .TRIM_VALUE(TRIM_VALUE),
    .SAMPLE_ENABLE(SAMPLE_ENABLE), .THRESHOLD_SELECT(THRESHOLD_SELECT),
    .IRQ_N_OE(IRQ_N_OE), .IRQ_N_OUT(IRQ_N_OUT)
);

// ---- testbench/rtc_irq_host_model.sv ----
// Host side of the interrupt wire with its pull-up.
module rtc_irq_host_model (
    input wire logic irq_oe,
    output logic irq_level
);
    timeunit 1ns;
    timeprecision 1ps;
    // The pull-up holds the wire high unless a party pulls it low.
    assign irq_level = irq_oe ? 1'h0 : 1'h1;
endmodule

// ---- testbench/rtc_status_monitor_interrupt_tb_top.sv ----
// Testbench of the status flags, supply monitor and interrupt output.
module rtc_status_monitor_interrupt_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================================
    // Signals and tasks
    localparam int SEC = 1000;
    localparam int HALF = 500;
    localparam int WIN = 20;
    localparam logic [3:0] CFG = 4'hE;
    localparam logic [3:0] STS = 4'hF;
    logic clk, rst_n = 1'h0, reg_write = 1'h0, trim_write = 1'h0, osc_halted = 1'h0;
    logic below_2v1 = 1'h0, below_1v3 = 1'h0, seconds_write = 1'h0;
    logic sample_enable, threshold_select, irq_n_oe, irq_n_out, irq_level;
    logic [3:0] reg_addr = 4'h0;
    logic [7:0] reg_wdata = 8'h00, reg_rdata, trim_value;
    rtc_status_pkg::period_tick_type period_tick = '0;
    rtc_status_pkg::alarm_time_type cur_time = '0;
    rtc_status_pkg::alarm_time_type wk_time = {3'h3, 6'h08, 7'h30};
    rtc_status_pkg::alarm_time_type dy_time = {3'h0, 6'h09, 7'h30};
    int error_cnt = 0, n_checks = 0;
    rtc_status_monitor_interrupt #(
        .SECOND_CYCLES(SEC), .HALF_SECOND_CYCLES(HALF), .WINDOW_CYCLES(WIN)
    ) dut_u (
        .CLK(clk), .RST_N(rst_n), .REG_ADDR(reg_addr), .REG_WRITE(reg_write),
        .REG_WDATA(reg_wdata), .TRIM_WRITE(trim_write), .REG_RDATA(reg_rdata),
        .TRIM_VALUE(trim_value), .OSC_HALTED(osc_halted), .BELOW_2V1(below_2v1),
        .BELOW_1V3(below_1v3), .SAMPLE_ENABLE(sample_enable),
        .THRESHOLD_SELECT(threshold_select), .PERIOD_TICK(period_tick),
        .SECONDS_WRITE(seconds_write), .CURRENT_TIME(cur_time),
        .WEEKLY_ALARM_TIME(wk_time), .DAILY_ALARM_TIME(dy_time),
        .IRQ_N_OE(irq_n_oe), .IRQ_N_OUT(irq_n_out)
    );
    rtc_irq_host_model host_u (.irq_oe(irq_n_oe), .irq_level(irq_level));
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic end_of_test();
        $display("checks=%0d errors=%0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(negedge clk);
        reg_addr = a;
        reg_wdata = d;
        reg_write = 1'h1;
        @(negedge clk);
        reg_write = 1'h0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] exp);
        @(negedge clk);
        reg_addr = a;
        repeat (2) @(negedge clk);
        chk(reg_rdata, exp);
    endtask
    task automatic tw(input logic [7:0] d);
        @(negedge clk);
        reg_wdata = d;
        trim_write = 1'h1;
        @(negedge clk);
        trim_write = 1'h0;
        @(negedge clk);
    endtask
    task automatic wait_oe(input logic v, input int bound);
        int i;
        for (i = 0; i < bound && irq_n_oe !== v; i++) @(negedge clk);
        chk({5'h00, irq_n_out, irq_level, irq_n_oe}, {5'h00, 1'h0, ~v, v});
        if (irq_n_oe !== v) end_of_test();
    endtask
    task automatic t_reset();
        rd(STS, 8'h10);
        rd(CFG, 8'h00);
        wr(CFG, 8'hFF);
        tw(8'h55);
        chk(trim_value, 8'h00);
        rd(CFG, 8'h00);
        wait_oe(1'h0, 1);
        wr(STS, 8'h50);
        rd(STS, 8'h10);
        wr(STS, 8'h00);
        rd(STS, 8'h00);
        tw(8'h55);
        chk(trim_value, 8'h55);
        wr(STS, 8'h20);
        rd(STS, 8'h20);
        osc_halted = 1'h1;
        repeat (4) @(negedge clk);
        osc_halted = 1'h0;
        rd(STS, 8'h00);
        $display("reset and flag test done");
    endtask
    task automatic t_supply();
        int i;
        int hi;
        hi = 0;
        seconds_write = 1'h1;
        @(negedge clk);
        seconds_write = 1'h0;
        wr(STS, 8'h00);
        below_2v1 = 1'h1;
        repeat (SEC + WIN + 8) @(negedge clk);
        rd(STS, 8'h40);
        for (i = 0; i < SEC + WIN; i++) begin
            @(negedge clk);
            if (sample_enable !== 1'h0) begin
                hi++;
            end
        end
        chk(8'(hi), 8'h00);
        wr(STS, 8'h80);
        repeat (SEC + WIN + 8) @(negedge clk);
        rd(STS, 8'h80);
        chk({7'h00, threshold_select}, 8'h01);
        below_1v3 = 1'h1;
        repeat (SEC + WIN + 8) @(negedge clk);
        rd(STS, 8'hC0);
        below_2v1 = 1'h0;
        below_1v3 = 1'h0;
        wr(STS, 8'h00);
        rd(STS, 8'h00);
        $display("supply test done");
    endtask
    task automatic t_periodic();
        for (int c = 1; c < 8; c++) begin
            wr(CFG, 8'(c));
            if (c == 1) begin
                wait_oe(1'h1, 8);
            end else if (c < 4) begin
                period_tick = 4'h8;
                @(negedge clk);
                period_tick = '0;
                wait_oe(1'h1, 8);
                wait_oe(1'h0, SEC);
            end else begin
                chk({7'h00, irq_n_oe}, 8'h00);
                period_tick = 4'h8 >> (c - 4);
                @(negedge clk);
                period_tick = '0;
                wait_oe(1'h1, 8);
                wr(STS, 8'h04);
                rd(STS, 8'h04);
                wr(STS, 8'h00);
                wait_oe(1'h0, 8);
            end
            wr(CFG, 8'h00);
            wait_oe(1'h0, HALF + 8);
        end
        $display("periodic test done");
    endtask
    task automatic t_alarm();
        logic [7:0] en;
        logic [7:0] fl;
        for (int k = 0; k < 2; k++) begin
            en = (k == 1) ? 8'h80 : 8'h40;
            fl = (k == 1) ? 8'h02 : 8'h01;
            wr(CFG, en);
            cur_time = (k == 1) ? wk_time : dy_time;
            wait_oe(1'h1, 8);
            wr(STS, fl);
            rd(STS, fl);
            wr(STS, 8'h00);
            wait_oe(1'h0, 8);
            rd(CFG, en);
            cur_time = '0;
            wr(CFG, 8'h00);
        end
        $display("alarm test done");
    endtask
    initial begin
        clk = 1'h0;
        forever #10 clk = ~clk;
    end
    initial begin
        repeat (16) @(negedge clk);
        rst_n = 1'h1;
        t_reset();
        t_supply();
        t_periodic();
        t_alarm();
        end_of_test();
    end
endmodule
